// ===== rtl/wss_entry_match.sv
`timescale 1ns/100ps
`default_nettype none

`include "wss_regs.svh"

module wss_entry_match
   import wss_pkg::*;
(
   // entry and calendar
   input  wire wss_entry_t entry,
   input  wire wss_now_t   now,
   input  wire logic       valid,
   // hits
   output logic            on_hit,
   output logic            off_hit
);

   // ON mask high byte, OFF mask low byte, top bits ignored
   wire [6:0] on_days  = entry.days[`WSS_ON_DAYS_LSB +: 7];   // (R19)
   wire [6:0] off_days = entry.days[`WSS_OFF_DAYS_LSB +: 7];  // (R19)
   wire [7:0] now_hour = now.hour;
   wire [7:0] now_min  = now.minute;
   wire [15:0] now_word = {now_hour, now_min};
   wire       on_day   = on_days[now.weekday];
   wire       off_day  = off_days[now.weekday];

   // weekday 7 indexes out of the mask and reads as no match
   assign on_hit  = valid && (now.weekday != 3'h7) && on_day &&
                    (entry.on_time == now_word);                   // (R6)
   assign off_hit = valid && (now.weekday != 3'h7) && off_day &&
                    (entry.off_time == now_word);                  // (R8)

endmodule

`default_nettype wire

// ===== rtl/wss_pkg.sv
package wss_pkg;

   // current calendar value from the clock source
   typedef struct packed {
      logic [2:0] weekday;   // 0 = sunday .. 6 = saturday
      logic [7:0] hour;
      logic [7:0] minute;
   } wss_now_t;

   // one schedule entry as held in three data words
   typedef struct packed {
      logic [15:0] days;
      logic [15:0] on_time;
      logic [15:0] off_time;
   } wss_entry_t;

   // host side word access to the schedule bank
   typedef struct packed {
      logic        wr_en;
      logic [9:0]  addr;
      logic [15:0] wdata;
   } wss_word_req_t;

endpackage

// ===== rtl/wss_regs.svh
`ifndef WSS_REGS_SVH
`define WSS_REGS_SVH

// schedule size
`define WSS_MAX_ENTRIES      20
`define WSS_WORDS_PER_ENTRY  3
`define WSS_BANK_WORDS       60
`define WSS_BYTES_PER_ENTRY  6
`define WSS_ADDR_W           10
`define WSS_WORD_W           16
`define WSS_ENTRY_BITS       48

// word offsets inside one entry
`define WSS_OFS_DAYS         2'h0
`define WSS_OFS_ON_TIME      2'h1
`define WSS_OFS_OFF_TIME     2'h2

// weekday word fields (bit 0 / bit 8 = sunday)
`define WSS_OFF_DAYS_LSB     0
`define WSS_ON_DAYS_LSB      8

// time word fields
`define WSS_MINUTE_LSB       0
`define WSS_HOUR_LSB         8

// reset values
`define WSS_WORD_RESET       16'h0000

`endif

// ===== rtl/wss_switch.sv
`timescale 1ns/100ps
`default_nettype none

`include "wss_regs.svh"

//Contract
// (R1) pulse mode: one-scan pulse at ON match
// (R2) one pulse/level setting for all entries
// (R3) level mode: ON sets, OFF clears output
// (R4) entry count configurable, at most twenty
// (R5) six bytes storage per configured entry
// (R6) ON time on flagged ON weekday turns on
// (R7) ON time hour 0-23, minute 0-59
// (R8) OFF time on flagged OFF weekday turns off
// (R9) OFF time hour 0-24, minute 0-59
// (R10) duplicate time: highest index entry wins
// (R11) lower OFF under higher ON is suppressed
// (R12) lower ON under higher OFF is suppressed
// (R13) register mode reads rewritable data words
// (R14) rewritten words act only at their time
// (R15) init input copies fixed values to words
// (R16) fixed mode: constants, pointer/init unused
// (R17) three words per entry: days, on, off
// (R18) pulse evaluated on execution rising edge
// (R19) weekday word packs ON and OFF masks
// (R20) compare once per scan, update at end
module wss_switch
   import wss_pkg::*;
#(
   // fixed schedule, entry 0 in the low 48 bits
   parameter logic [20*48-1:0] FIXED_ENTRIES = '0
)(
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   sys_rst,
   // scan and calendar
   input  wire logic                   scan_tick,
   input  wire logic                   exec_enable,
   input  wire wss_now_t               now,
   // configuration
   input  wire logic                   use_registers,
   input  wire logic                   pulse_mode,
   input  wire logic [4:0]             entry_count,
   input  wire logic [`WSS_ADDR_W-1:0] first_schedule_word,
   input  wire logic                   load_defaults_input,
   // data word access
   input  wire wss_word_req_t          word_req,
   output logic [`WSS_WORD_W-1:0]      word_rdata,
   output logic                        word_hit,
   // results
   output logic                        switch_out,
   output logic [6:0]                  program_bytes
);

   localparam int N  = `WSS_MAX_ENTRIES;
   localparam int EB = `WSS_ENTRY_BITS;

   // schedule data words, all in flops: a scan sees a rewritten
   // word in the very next cycle, at the cost of sixty registers
   logic [`WSS_WORD_W-1:0] bank [`WSS_BANK_WORDS];

   // fixed schedule split into words, same order as the bank
   wire [`WSS_WORD_W-1:0] fixed_word [`WSS_BANK_WORDS];

   // scan history
   logic prev_exec;
   logic prev_on_fire;

   // clamped entry count; counts above twenty act as twenty
   wire [4:0] eff_count = (entry_count > 5'(N)) ? 5'(N) : entry_count; // (R4)

   // storage figure grows linearly with entries
   // a report only: the bank is always sized for twenty entries
   assign program_bytes = 7'(eff_count) * 7'(`WSS_BYTES_PER_ENTRY);    // (R5)

   // word window decode relative to the first word
   // an address below the first word wraps high and misses unless the window wraps past the top address
   wire [`WSS_ADDR_W-1:0] rel_addr = word_req.addr - first_schedule_word;
   wire [`WSS_ADDR_W-1:0] win_len  =
      `WSS_ADDR_W'(eff_count) * `WSS_ADDR_W'(`WSS_WORDS_PER_ENTRY);    // (R17)
   wire in_window = use_registers && (rel_addr < win_len);             // (R16)
   wire [5:0] bank_idx = rel_addr[5:0];

   // write qualifiers; init wins over a word write in one cycle
   wire do_write  = word_req.wr_en && in_window;
   wire do_init   = load_defaults_input && use_registers;              // (R16)

   // bank writes, init copies every fixed entry at once
   // reset clears all sixty words; a bank never loaded reads zero
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int k = 0; k < `WSS_BANK_WORDS; k++) begin
            bank[k] <= `WSS_WORD_RESET;
         end
      end else if (do_init) begin
         for (int k = 0; k < `WSS_BANK_WORDS; k++) begin
            bank[k] <= fixed_word[k];                                  // (R15)
         end
      end else if (do_write) begin
         bank[bank_idx] <= word_req.wdata;                             // (R13)
      end
   end

   // registered read back of the window, zero outside it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         word_rdata <= `WSS_WORD_RESET;
      end else begin
         word_rdata <= in_window ? bank[bank_idx] : `WSS_WORD_RESET;
      end
   end

   // hit flag lines up with the read data
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         word_hit <= 1'b0;
      end else begin
         word_hit <= in_window;
      end
   end

   // per-entry compare and highest-index priority chain
   // each entry compares on its own; priority comes after
   wire [N-1:0] on_hit;
   wire [N-1:0] off_hit;
   wire [N:0]   any_chain;
   wire [N:0]   on_chain;

   // chain seeds: below entry 0 nothing hits
   assign any_chain[0] = 1'b0;
   assign on_chain[0]  = 1'b0;

   // twenty stages ripple in one cycle; the long path of the block
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_entry
         // bank slots of this entry: days, ON time, OFF time
         localparam int DAYS_W = 3*i + `WSS_OFS_DAYS;
         localparam int ON_W   = 3*i + `WSS_OFS_ON_TIME;
         localparam int OFF_W  = 3*i + `WSS_OFS_OFF_TIME;
         wss_entry_t fixed_e;
         wss_entry_t reg_e;
         wss_entry_t sel_e;
         wire        live;
         wire        hit_any;
         // constant entry, folded away when unused
         assign fixed_e = FIXED_ENTRIES[i*EB +: EB];             // (R16)
         // the same constants as words for the init copy
         assign fixed_word[DAYS_W] = fixed_e.days;               // (R15)
         assign fixed_word[ON_W]   = fixed_e.on_time;
         assign fixed_word[OFF_W]  = fixed_e.off_time;
         // bank entry, days word first
         assign reg_e = {bank[DAYS_W], bank[ON_W], bank[OFF_W]}; // (R17)
         // source select: bank words or constants
         assign sel_e = use_registers ? reg_e : fixed_e;         // (R13)
         // entries past the count never hit
         assign live  = 5'(i) < eff_count;                       // (R4)
         wss_entry_match u_match (
            .entry   (sel_e),
            .now     (now),
            .valid   (live),
            .on_hit  (on_hit[i]),
            .off_hit (off_hit[i])
         );
         // a higher hitting entry overrides all lower ones
         assign hit_any        = on_hit[i] | off_hit[i];
         assign any_chain[i+1] = any_chain[i] | hit_any;         // (R10)
         assign on_chain[i+1]  = hit_any ? on_hit[i] : on_chain[i]; // (R11)
      end
   endgenerate

   // winner's action; an entry hitting both ways turns on
   // no hit at all leaves both low and the level holds
   wire act_on  = any_chain[N] && on_chain[N];                         // (R12)
   wire act_off = any_chain[N] && !on_chain[N];                        // (R11)

   // pulse fires once per ON minute, or on a fresh execution start
   // a held minute across many scans still gives a single pulse
   wire exec_rise = exec_enable && !prev_exec;
   wire on_fire   = exec_enable && act_on;
   wire pulse_now = on_fire && (!prev_on_fire || exec_rise);           // (R18)

   // level next value; words only matter when a time matches
   wire next_level = act_on  ? 1'b1 :                                  // (R14)
                     act_off ? 1'b0 : switch_out;                      // (R3)

   // one mode bit picks for all entries; disabled forces low
   wire mode_out   = pulse_mode ? pulse_now : next_level;              // (R2)
   wire next_out   = exec_enable ? mode_out : 1'b0;

   // output moves only on the scan boundary
   // between scans it stands, even while the time moves on
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         switch_out <= 1'b0;
      end else if (scan_tick) begin
         switch_out <= next_out;                                       // (R20)
      end
   end

   // execution history for the rising-edge test
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         prev_exec <= 1'b0;
      end else if (scan_tick) begin
         prev_exec <= exec_enable;
      end
   end

   // ON history; only a fresh ON win may pulse again
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         prev_on_fire <= 1'b0;
      end else if (scan_tick) begin
         prev_on_fire <= on_fire;                                      // (R1)
      end
   end

endmodule

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench
   import wss_pkg::*;
;
   // entry 0 on 8:00 off 9:00, entry 1 on 9:00 off 10:00, every day
   localparam logic [959:0] FIX = {864'h0, 48'h7F7F_0900_0A00,
                                   48'h7F7F_0800_0900};
   logic          ref_clk, sys_rst, ur, pm, ex, ld, sw, hit, eo;
   logic [4:0]    cnt;
   logic [9:0]    fw;
   logic [15:0]   rdat;
   logic [6:0]    pb;
   logic [31:0]   seed, r;
   wss_word_req_t wq;
   wss_now_t      now;
   logic          tick;
   int            bank[60], bad_count, num_checks, pw, pe, a;
   logic [15:0]   tv[4] = '{16'h0800, 16'h0900, 16'h171E, 16'h1800};
   logic [15:0]   tl[6] = '{16'h073B, 16'h0800, 16'h081E, 16'h0900,
                            16'h091E, 16'h0A00};

   wss_calendar i_wss_calendar (.ref_clk, .now, .scan_tick(tick));
   wss_switch #(.FIXED_ENTRIES(FIX)) i_wss_switch (.ref_clk, .sys_rst,
      .scan_tick(tick), .exec_enable(ex), .now, .use_registers(ur),
      .pulse_mode(pm), .entry_count(cnt), .first_schedule_word(fw),
      .load_defaults_input(ld), .word_req(wq), .word_rdata(rdat),
      .word_hit(hit), .switch_out(sw), .program_bytes(pb));

   // 25 MHz scan clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask

   function automatic int cl();
      return cnt > 20 ? 20 : cnt;
   endfunction

   // model source word: bank in register mode, constants otherwise
   function automatic int w(input int i);
      return ur ? bank[i] : FIX[i / 3 * 48 + (2 - i % 3) * 16 +: 16];
   endfunction

   // word write, mirrored in the bank only if the design must take it
   task automatic wr(input int a, input logic [15:0] d);
      @(negedge ref_clk);
      wq <= {1'b1, fw + 10'(a), d};
      if (ur && !ld && a < 3 * cl()) bank[a] = d;
      @(negedge ref_clk);
      wq.wr_en <= 1'b0;
   endtask

   task automatic rd(input int a, input logic [16:0] e);
      @(negedge ref_clk);
      wq <= {1'b0, fw + 10'(a), 16'h0000};
      @(negedge ref_clk);
      check({hit, rdat}, e);
   endtask

   // scans through the model; highest index decides, ON beats OFF
   task automatic scan(input logic [2:0] d, input logic [15:0] t, input int n);
      int v;
      i_wss_calendar.step({d, t}, n);
      repeat (n) begin
         v = 0;
         for (int k = 0; k < cl(); k++) begin
            if (w(3 * k) >> (8 + d) & 1 && w(3 * k + 1) == t) v = 1;
            else if (w(3 * k) >> d & 1 && w(3 * k + 2) == t) v = 2;
         end
         if (!ex) eo = 1'b0;
         else if (pm) eo = v == 1 && (pw != 1 || !pe);
         else if (v != 0) eo = v == 1;
         pw = v;
         pe = ex;
      end
      check(sw, eo);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // main sequence
   initial begin
      seed = 32'hA83ECEE5;
      {sys_rst, ur, pm, ld, eo} = 5'h10;
      {ex, pe, pw, bad_count, num_checks} = {1'b1, 32'h1, 96'h0};
      {cnt, fw, wq} = {5'h02, 10'h0C8, 27'h0};
      repeat (6) @(negedge ref_clk);
      sys_rst = 1'b0;
      wr(0, 16'h1234);
      foreach (tl[i]) scan(3'h1, tl[i], 1);
      // fixed mode ignores init and the write; bank keeps reset words
      foreach (bank[i]) bank[i] = w(i);
      ld = 1'b1;
      @(negedge ref_clk);
      {ur, ld} = 2'h2;
      rd(0, 17'h10000);
      // defaults into the bank, then swap the two entries
      ld = 1'b1;
      @(negedge ref_clk);
      ld = 1'b0;
      rd(4, 17'h10900);
      rd(6, 17'h00000);
      wr(1, 16'h0900);
      wr(2, 16'h0A00);
      wr(4, 16'h0800);
      wr(5, 16'h0900);
      wr(6, 16'h0A00);
      rd(1, 17'h10900);
      foreach (tl[i]) scan(3'h1, tl[i], 1);
      // pulse: held match pulses once, exec restart pulses again
      pm = 1'b1;
      scan(3'h1, 16'h073B, 1);
      scan(3'h1, 16'h0800, 2);
      ex = 1'b0;
      scan(3'h1, 16'h0800, 1);
      ex = 1'b1;
      scan(3'h1, 16'h0800, 1);
      // random overlapping entries, reserved bits, end of day
      {pm, cnt} = 6'h15;
      @(negedge ref_clk);
      check(pb, 7'h78);
      repeat (80) begin
         r = $random(seed);
         a = r[5:0] % 60;
         wr(a, a % 3 == 0 ? r[31:16] : tv[r[9:8] % (a % 3 + 2)]);
         scan(3'(r[12:10] % 7), tv[r[15:14]], 1);
      end
      stop_test();
   end
endmodule

`default_nettype wire

// ===== tb/wss_calendar.sv
`timescale 1ns/100ps
`default_nettype none

module wss_calendar
   import wss_pkg::*;
(
   // scan clock
   input  wire logic ref_clk,
   // calendar and scan marker
   output var wss_now_t now = '0,
   output logic      scan_tick = 1'b0
);
   // one time for n back to back scans, marker low again after
   task automatic step(input wss_now_t t, input int n);
      @(negedge ref_clk);
      now <= t;
      scan_tick <= 1'b1;
      repeat (n) @(negedge ref_clk);
      scan_tick <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ===== tb/wss_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module wss_monitor
   import wss_pkg::*;
(
   // clock and reset
   input wire logic          ref_clk,
   input wire logic          sys_rst,
   // scan side
   input wire logic          scan_tick,
   input wire logic          exec_enable,
   input wire wss_now_t      now,
   input wire logic          pulse_mode,
   input wire logic [4:0]    entry_count,
   // words and results
   input wire logic [9:0]    first_schedule_word,
   input wire wss_word_req_t word_req,
   input wire logic [15:0]   word_rdata,
   input wire logic          word_hit,
   input wire logic          switch_out,
   input wire logic [6:0]    program_bytes
);
   // clamped count and window test
   wire logic [6:0] cnt = (entry_count > 5'h14) ? 7'h14 : {2'h0, entry_count};
   wire logic [9:0] rel = word_req.addr - first_schedule_word;
   wire logic       inwin = rel < 10'(cnt) * 10'h003;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   chk_bytes_used: assert property (program_bytes == 7'(cnt * 7'h06))
      else $error("program byte count wrong");
   chk_scan_gate: assert property (!$past(scan_tick) && !$past(sys_rst)
      |-> $stable(switch_out)) else $error("output moved between scans");
   chk_exec_off: assert property (scan_tick && !exec_enable
      |=> !switch_out) else $error("output on while disabled");
   chk_rise_cause: assert property ($rose(switch_out)
      |-> $past(scan_tick && exec_enable)) else $error("rise without scan");
   chk_fall_cause: assert property ($fell(switch_out)
      |-> $past(scan_tick || sys_rst)) else $error("fall without scan");
   chk_pulse_once: assert property (pulse_mode && $stable(pulse_mode)
      && scan_tick && $past(scan_tick) && $stable(now)
      && $stable(exec_enable) && switch_out |=> !switch_out)
      else $error("pulse repeated for held match");
   chk_window_hit: assert property (word_hit |-> $past(inwin))
      else $error("hit outside window");
   chk_miss_zero: assert property (!word_hit |-> word_rdata == 16'h0000)
      else $error("read data without hit");
endmodule

bind wss_switch wss_monitor i_wss_monitor (.ref_clk, .sys_rst, .scan_tick,
   .exec_enable, .now, .pulse_mode, .entry_count, .first_schedule_word,
   .word_req, .word_rdata, .word_hit, .switch_out, .program_bytes);

`default_nettype wire
